/* hdl/conversion_engine.sv */
`default_nettype none
module conversion_engine
  import thermo_pkg::*;
#(
  parameter int unsigned CYCLES = CONV_CYCLES
) (
  input  wire logic clk,       // System clock
  input  wire logic reset,     // Asynchronous reset
  input  wire logic start,     // Begin conversion pulse
  input  wire logic stop,      // Halt continuous pulse
  input  wire logic one_shot,  // Single conversion mode
  output var  logic busy,      // Conversion in progress
  output var  logic done       // Conversion complete pulse
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic          repeat_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q    <= '0;
      repeat_q <= 1'b0;
      busy     <= 1'b0;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        repeat_q <= ~one_shot;
        if (!busy)
        begin
          busy  <= 1'b1;
          cnt_q <= '0;
        end
      end
      else if (stop)
      begin
        repeat_q <= 1'b0;
      end
      if (busy && !start)
      begin
        if (cnt_q == LAST)
        begin
          done  <= 1'b1;
          cnt_q <= '0;
          busy  <= repeat_q && !stop;
        end
        else
        begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule // conversion_engine
`default_nettype wire

/* hdl/pin_sync.sv */
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // System clock
  input  wire logic         reset,  // Asynchronous reset
  input  wire logic [W-1:0] din,    // Asynchronous inputs
  output var  logic [W-1:0] dout    // Synchronised inputs
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

/* hdl/thermo_pkg.sv */
`default_nettype none
package thermo_pkg;
  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_TEMP  = 8'hAA;
  localparam logic [7:0] CMD_READ_COUNT = 8'hA0;
  localparam logic [7:0] CMD_READ_SLOPE = 8'hA9;
  localparam logic [7:0] CMD_START      = 8'hEE;
  localparam logic [7:0] CMD_STOP       = 8'h22;
  localparam logic [7:0] CMD_WRITE_HIGH = 8'h01;
  localparam logic [7:0] CMD_WRITE_LOW  = 8'h02;
  localparam logic [7:0] CMD_READ_HIGH  = 8'hA1;
  localparam logic [7:0] CMD_READ_LOW   = 8'hA2;
  localparam logic [7:0] CMD_WRITE_CFG  = 8'h0C;
  localparam logic [7:0] CMD_READ_CFG   = 8'hAC;
  // ---------------------------------------------------------------
  // Widths and configuration layout
  // ---------------------------------------------------------------
  localparam int CMD_W  = 8;
  localparam int WORD_W = 9;
  localparam int CFG_W  = 8;
  localparam int CNT_W  = 4;
  localparam logic [CNT_W-1:0] CMD_LAST = 4'h7;
  localparam logic [CNT_W-1:0] LEN_WORD = 4'h9;
  localparam logic [CNT_W-1:0] LEN_CFG  = 4'h8;
  localparam int CFG_ONE_SHOT = 0;
  localparam int CFG_CPU      = 1;
  localparam int CFG_NVB      = 4;
  localparam int CFG_TLF      = 5;
  localparam int CFG_THF      = 6;
  localparam int CFG_DONE     = 7;
  localparam logic [1:0] CFG_FIXED = 2'h2;
  localparam logic [WORD_W-1:0] LIMIT_RESET = 9'h000;
  localparam logic ONE_SHOT_RESET = 1'b0;
  localparam logic CPU_RESET      = 1'b0;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CONV_TIME_MS  = 750;
  localparam int unsigned NV_WRITE_MS   = 10;
  localparam int unsigned CONV_CYCLES   = CONV_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned NV_CYCLES     = NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // Link states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_COMMAND,
    ST_READ,
    ST_WRITE,
    ST_IGNORE
  } link_state_t;
endpackage
`default_nettype wire

/* hdl/thermometer_serial_command_decoder.sv */
`default_nettype none
module thermometer_serial_command_decoder
  import thermo_pkg::*;
#(
  parameter int unsigned CONV_LEN = CONV_CYCLES,
  parameter int unsigned NV_LEN   = NV_CYCLES
) (
  input  wire logic              clk,                       // System clock
  input  wire logic              reset,                     // Asynchronous reset
  input  wire logic              serial_clock_convert_pin,  // Serial clock pin
  input  wire logic              xfer_rst,                  // Transfer reset pin
  input  wire logic              dq_in,                     // Data pin level
  output var  logic              dq_out,                    // Data pin drive value
  output var  logic              dq_oe,                     // Data pin drive enable
  input  wire logic [WORD_W-1:0] meas_temp,                 // Converted temperature
  input  wire logic [WORD_W-1:0] meas_count,                // Count remaining
  input  wire logic [WORD_W-1:0] meas_slope,                // Slope accumulator
  output var  logic [WORD_W-1:0] high_limit_register,       // High limit
  output var  logic [WORD_W-1:0] low_limit_register,        // Low limit
  output var  logic              single_conversion_bit,     // One-shot mode
  output var  logic              cpu_mode,                  // Three-wire use bit
  output var  logic              conv_busy,                 // Conversion running
  output var  logic              nv_busy                    // Nonvolatile write busy
);
  localparam int NW = $clog2(NV_LEN + 1);
  localparam logic [NW-1:0] NV_LAST = NW'(NV_LEN - 1);

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [2:0] pins_s;
  logic       sclk_s;
  logic       rst_s;
  logic       dq_s;
  logic       sclk_prev_q;
  logic       sclk_rise;
  logic       sclk_fall;

  pin_sync #(
    .W (3)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   ({serial_clock_convert_pin, xfer_rst, dq_in}),
    .dout  (pins_s)
  );

  assign sclk_s    = pins_s[2];
  assign rst_s     = pins_s[1];
  assign dq_s      = pins_s[0];
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
    end
  end

  // ---------------------------------------------------------------
  // Command helpers
  // ---------------------------------------------------------------
  function automatic logic is_read(input logic [CMD_W-1:0] c);
    return c == CMD_READ_TEMP || c == CMD_READ_COUNT || c == CMD_READ_SLOPE ||
           c == CMD_READ_HIGH || c == CMD_READ_LOW || c == CMD_READ_CFG;
  endfunction

  function automatic logic is_write(input logic [CMD_W-1:0] c);
    return c == CMD_WRITE_HIGH || c == CMD_WRITE_LOW || c == CMD_WRITE_CFG;
  endfunction

  function automatic logic [CNT_W-1:0] data_len(input logic [CMD_W-1:0] c);
    return (c == CMD_READ_CFG || c == CMD_WRITE_CFG) ? LEN_CFG : LEN_WORD;
  endfunction

  // ---------------------------------------------------------------
  // Link state
  // ---------------------------------------------------------------
  link_state_t        state_q;
  logic [CNT_W-1:0]   bit_cnt_q;
  logic [CMD_W-1:0]   cmd_q;
  logic [CMD_W-1:0]   cmd_d;
  logic [WORD_W-1:0]  rx_q;
  logic [WORD_W-1:0]  rx_d;
  logic [WORD_W-1:0]  tx_q;
  logic [WORD_W-1:0]  read_word;
  logic [CFG_W-1:0]   cfg_word;
  logic               wr_done;
  logic               start_pulse;
  logic               stop_pulse;
  logic               conv_done;
  logic [WORD_W-1:0]  temp_q;
  logic [WORD_W-1:0]  count_q;
  logic [WORD_W-1:0]  slope_q;
  logic               thf_q;
  logic               tlf_q;
  logic [NW-1:0]      nv_cnt_q;

  assign cmd_d    = {dq_s, cmd_q[CMD_W-1:1]};
  assign rx_d     = {dq_s, rx_q[WORD_W-1:1]};
  assign wr_done  = state_q == ST_WRITE && sclk_rise &&
                    bit_cnt_q == data_len(cmd_q) - 1'b1;
  assign cfg_word = {~conv_busy, thf_q, tlf_q, nv_busy, CFG_FIXED,
                     cpu_mode, single_conversion_bit};

  always_comb
  begin
    unique case (cmd_d)
      CMD_READ_TEMP:  read_word = temp_q;
      CMD_READ_COUNT: read_word = count_q;
      CMD_READ_SLOPE: read_word = slope_q;
      CMD_READ_HIGH:  read_word = high_limit_register;
      CMD_READ_LOW:   read_word = low_limit_register;
      CMD_READ_CFG:   read_word = {1'b0, cfg_word};
      default:        read_word = '0;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= '0;
      cmd_q       <= '0;
      rx_q        <= '0;
      tx_q        <= '0;
      start_pulse <= 1'b0;
      stop_pulse  <= 1'b0;
    end
    else
    begin
      start_pulse <= 1'b0;
      stop_pulse  <= 1'b0;
      if (!rst_s)
      begin
        state_q <= ST_IDLE;
      end
      else
      begin
        unique case (state_q)
          ST_IDLE:
          begin
            state_q   <= ST_COMMAND;
            bit_cnt_q <= '0;
          end
          ST_COMMAND:
          begin
            if (sclk_rise)
            begin
              cmd_q     <= cmd_d;
              bit_cnt_q <= bit_cnt_q + 1'b1;
              if (bit_cnt_q == CMD_LAST)
              begin
                bit_cnt_q   <= '0;
                tx_q        <= read_word;
                start_pulse <= cmd_d == CMD_START;
                stop_pulse  <= cmd_d == CMD_STOP;
                if (is_read(cmd_d))
                  state_q <= ST_READ;
                else if (is_write(cmd_d))
                  state_q <= ST_WRITE;
                else
                  state_q <= ST_IGNORE;
              end
            end
          end
          ST_READ:
          begin
            if (sclk_fall)
              tx_q <= tx_q >> 1;
            if (sclk_rise)
            begin
              bit_cnt_q <= bit_cnt_q + 1'b1;
              if (bit_cnt_q == data_len(cmd_q) - 1'b1)
                state_q <= ST_IGNORE;
            end
          end
          ST_WRITE:
          begin
            if (sclk_rise)
            begin
              rx_q      <= rx_d;
              bit_cnt_q <= bit_cnt_q + 1'b1;
              if (wr_done)
                state_q <= ST_IGNORE;
            end
          end
          ST_IGNORE: state_q <= ST_IGNORE;
          default:   state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Data pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dq_out <= 1'b0;
      dq_oe  <= 1'b0;
    end
    else if (!rst_s || state_q != ST_READ)
    begin
      dq_oe <= 1'b0;
    end
    else if (sclk_fall)
    begin
      dq_out <= tx_q[0];
      dq_oe  <= 1'b1;
    end
    else if (sclk_s)
    begin
      dq_oe <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers written over the link
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      high_limit_register   <= LIMIT_RESET;
      low_limit_register    <= LIMIT_RESET;
      single_conversion_bit <= ONE_SHOT_RESET;
      cpu_mode              <= CPU_RESET;
    end
    else if (wr_done && rst_s)
    begin
      unique case (cmd_q)
        CMD_WRITE_HIGH: high_limit_register <= rx_d;
        CMD_WRITE_LOW:  low_limit_register  <= rx_d;
        CMD_WRITE_CFG:
        begin
          single_conversion_bit <= rx_d[CFG_ONE_SHOT + 1];
          cpu_mode              <= rx_d[CFG_CPU + 1];
        end
        default: cpu_mode <= cpu_mode;
      endcase
    end
  end

  // Flags set by conversion results, cleared by writing zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      thf_q <= 1'b0;
      tlf_q <= 1'b0;
    end
    else
    begin
      if (conv_done && $signed(meas_temp) >= $signed(high_limit_register))
      begin
        thf_q <= 1'b1;
      end
      else if (wr_done && rst_s && cmd_q == CMD_WRITE_CFG)
      begin
        thf_q <= thf_q & rx_d[CFG_THF + 1];
      end
      if (conv_done && $signed(meas_temp) <= $signed(low_limit_register))
      begin
        tlf_q <= 1'b1;
      end
      else if (wr_done && rst_s && cmd_q == CMD_WRITE_CFG)
      begin
        tlf_q <= tlf_q & rx_d[CFG_TLF + 1];
      end
    end
  end

  // Nonvolatile busy window after each write
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      nv_cnt_q <= '0;
      nv_busy  <= 1'b0;
    end
    else if (wr_done && rst_s)
    begin
      nv_cnt_q <= '0;
      nv_busy  <= 1'b1;
    end
    else if (nv_busy)
    begin
      nv_cnt_q <= nv_cnt_q + 1'b1;
      nv_busy  <= nv_cnt_q != NV_LAST;
    end
  end

  // ---------------------------------------------------------------
  // Conversion control and results
  // ---------------------------------------------------------------
  conversion_engine #(
    .CYCLES (CONV_LEN)
  ) u_conv (
    .clk      (clk),
    .reset    (reset),
    .start    (start_pulse),
    .stop     (stop_pulse),
    .one_shot (single_conversion_bit),
    .busy     (conv_busy),
    .done     (conv_done)
  );

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      temp_q  <= '0;
      count_q <= '0;
      slope_q <= '0;
    end
    else if (conv_done)
    begin
      temp_q  <= meas_temp;
      count_q <= meas_count;
      slope_q <= meas_slope;
    end
  end
endmodule // thermometer_serial_command_decoder
`default_nettype wire

/* test/host_model.sv */
`default_nettype none
module host_model (
  input  wire logic clk,       // System clock
  input  wire logic dq_wire,   // Resolved data line
  output var  logic sclk,      // Serial clock pin
  output var  logic xfer_rst,  // Transfer reset pin
  output var  logic host_drv,  // Host data value
  output var  logic host_oe    // Host data enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sclk = 1'b1;
    xfer_rst = 1'b0;
    host_drv = 1'b0;
    host_oe = 1'b0;
  end
  // ---------------------------------------------------------------
  // One framed transaction, 200 ns serial clock, idle high
  // ---------------------------------------------------------------
  task automatic run(input logic [7:0] cmd, input int nd, input logic [8:0] wd,
                     input bit rd, output logic [11:0] rq);
    int i;
    rq = 12'h000;
    @(posedge clk);
    xfer_rst <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 8 + nd; i++)
    begin
      @(posedge clk);
      sclk <= 1'b0;
      host_oe <= (i < 8) || !rd;
      host_drv <= (i < 8) ? cmd[i] : ((i < 17) ? wd[i-8] : 1'b0);
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      if (i >= 8) rq[i-8] = dq_wire;
      @(posedge clk);
    end
    @(posedge clk);
    host_oe <= 1'b0;
    repeat (4) @(posedge clk);
    xfer_rst <= 1'b0;
    repeat (24) @(posedge clk);
  endtask
endmodule // host_model
`default_nettype wire

/* test/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import thermo_pkg::*;
  localparam int unsigned CONV_T = 50;
  localparam int unsigned NV_T   = 20;
  logic              clk, reset, dq_in, dq_out, dq_oe, sclk, xrst, host_drv, host_oe;
  logic [WORD_W-1:0] meas_temp, meas_count, meas_slope, hi_lim, lo_lim;
  logic              one_shot, cpu, conv_busy, nv_busy;
  logic [11:0]       rd;
  logic [31:0]       seed, r;
  logic [8:0]        m_hi, m_lo;
  logic [1:0]        m_flg;
  logic [8:0]        m_cap [3];
  logic [7:0]        rcmd [3];
  int                error_cnt, n_checks, i, k;
  assign dq_in = dq_oe ? dq_out : (host_oe ? host_drv : 1'b1);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  thermometer_serial_command_decoder #(.CONV_LEN(CONV_T), .NV_LEN(NV_T))
    thermometer_serial_command_decoder_i (
    .clk(clk), .reset(reset), .serial_clock_convert_pin(sclk), .xfer_rst(xrst),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .meas_temp(meas_temp),
    .meas_count(meas_count), .meas_slope(meas_slope), .high_limit_register(hi_lim),
    .low_limit_register(lo_lim), .single_conversion_bit(one_shot), .cpu_mode(cpu),
    .conv_busy(conv_busy), .nv_busy(nv_busy));
  host_model host_model_i (.clk(clk), .dq_wire(dq_in), .sclk(sclk), .xfer_rst(xrst),
    .host_drv(host_drv), .host_oe(host_oe));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic new_meas();
    r = xs();
    @(posedge clk);
    meas_temp <= r[8:0];
    meas_count <= r[17:9];
    meas_slope <= r[26:18];
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen timeout");
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    seed = 32'h000151F4;
    reset = 1'b1;
    meas_temp = 9'h000;
    meas_count = 9'h000;
    meas_slope = 9'h000;
    rcmd = '{CMD_READ_TEMP, CMD_READ_COUNT, CMD_READ_SLOPE};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    host_model_i.run(CMD_READ_HIGH, 12, 9'h000, 1, rd);
    check("high after reset", {3'h7, LIMIT_RESET}, rd);
    host_model_i.run(CMD_READ_LOW, 12, 9'h000, 1, rd);
    check("low after reset", {3'h7, LIMIT_RESET}, rd);
    $display("test reset values done");
    for (k = 0; k < 3; k++)
    begin
      r = xs();
      m_hi = r[8:0];
      m_lo = r[17:9];
      host_model_i.run(CMD_WRITE_HIGH, 9, m_hi, 0, rd);
      host_model_i.run(CMD_WRITE_LOW, 12, m_lo, 0, rd);
      check("high register", {3'h0, m_hi}, {3'h0, hi_lim});
      check("low register", {3'h0, m_lo}, {3'h0, lo_lim});
      check("nv window over", 12'h000, {11'h0, nv_busy});
      host_model_i.run(CMD_READ_HIGH, 12, 9'h000, 1, rd);
      check("high read", {3'h7, m_hi}, rd);
      host_model_i.run(CMD_READ_LOW, 12, 9'h000, 1, rd);
      check("low read", {3'h7, m_lo}, rd);
    end
    $display("test limits done");
    host_model_i.run(CMD_WRITE_HIGH, 5, ~m_hi, 0, rd);
    check("short write", {3'h0, m_hi}, {3'h0, hi_lim});
    host_model_i.run(8'h55, 12, 9'h000, 1, rd);
    check("unknown read", 12'hFFF, rd);
    host_model_i.run(8'h03, 9, ~m_lo, 0, rd);
    check("unknown write", {3'h0, m_lo}, {3'h0, lo_lim});
    $display("test refusals done");
    host_model_i.run(CMD_WRITE_CFG, 8, 9'h003, 0, rd);
    check("one-shot bit", 12'h001, {11'h0, one_shot});
    check("cpu bit", 12'h001, {11'h0, cpu});
    host_model_i.run(CMD_READ_CFG, 12, 9'h000, 1, rd);
    check("config read", 12'hF8B, rd);
    $display("test config done");
    new_meas();
    m_cap = '{r[8:0], r[17:9], r[26:18]};
    host_model_i.run(CMD_START, 0, 9'h000, 0, rd);
    check("one-shot busy", 12'h001, {11'h0, conv_busy});
    for (i = 0; i < 200 && conv_busy !== 1'b0; i++) @(posedge clk);
    repeat (3 * CONV_T) @(posedge clk);
    check("one-shot idle", 12'h000, {11'h0, conv_busy});
    new_meas();
    for (k = 0; k < 3; k++)
    begin
      host_model_i.run(rcmd[k], 12, 9'h000, 1, rd);
      check("captured read", {3'h7, m_cap[k]}, rd);
    end
    m_flg = {$signed(m_cap[0]) >= $signed(m_hi), $signed(m_cap[0]) <= $signed(m_lo)};
    host_model_i.run(CMD_READ_CFG, 12, 9'h000, 1, rd);
    check("flags read", {4'hF, 1'b1, m_flg, 5'h0B}, rd);
    $display("test one-shot done");
    host_model_i.run(CMD_WRITE_CFG, 8, 9'h000, 0, rd);
    check("continuous bit", 12'h000, {11'h0, one_shot});
    host_model_i.run(CMD_START, 0, 9'h000, 0, rd);
    new_meas();
    m_cap[0] = r[8:0];
    repeat (3 * CONV_T) @(posedge clk);
    check("continuous busy", 12'h001, {11'h0, conv_busy});
    host_model_i.run(CMD_READ_TEMP, 12, 9'h000, 1, rd);
    check("repeat capture", {3'h7, m_cap[0]}, rd);
    host_model_i.run(CMD_STOP, 0, 9'h000, 0, rd);
    for (i = 0; i < CONV_T + 20 && conv_busy !== 1'b0; i++) @(posedge clk);
    check("halt busy", 12'h000, {11'h0, conv_busy});
    repeat (3 * CONV_T) @(posedge clk);
    check("halt idle", 12'h000, {11'h0, conv_busy});
    $display("test continuous done");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire

/* test/thermo_properties.sv */
`default_nettype none
module thermo_properties
  import thermo_pkg::*;
#(
  parameter int unsigned CONV_LEN = 50,
  parameter int unsigned NV_LEN   = 20
) (
  input wire logic              clk,                       // System clock
  input wire logic              reset,                     // Asynchronous reset
  input wire logic              serial_clock_convert_pin,  // Serial clock pin
  input wire logic              xfer_rst,                  // Transfer reset pin
  input wire logic              dq_out,                    // Data drive value
  input wire logic              dq_oe,                     // Data drive enable
  input wire logic [WORD_W-1:0] high_limit_register,       // High limit
  input wire logic [WORD_W-1:0] low_limit_register,        // Low limit
  input wire logic              single_conversion_bit,     // One-shot mode
  input wire logic              conv_busy,                 // Conversion running
  input wire logic              nv_busy                    // Nonvolatile busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] nv_cnt_q;
  logic [31:0] conv_cnt_q;
  // ---------------------------------------------------------------
  // Busy window lengths
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
    if (reset) nv_cnt_q <= 32'h0;
    else nv_cnt_q <= nv_busy ? nv_cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge clk or posedge reset)
    if (reset) conv_cnt_q <= 32'h0;
    else conv_cnt_q <= conv_busy ? conv_cnt_q + 32'h1 : 32'h0;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_release_high;
    serial_clock_convert_pin [*4] |-> !dq_oe;
  endproperty
  a_release_high: assert property (p_release_high)
    else $error("data pin driven while serial clock high");
  property p_release_rst;
    !xfer_rst [*4] |-> !dq_oe;
  endproperty
  a_release_rst: assert property (p_release_rst)
    else $error("data pin driven with transfer reset low");
  property p_drive_after_fall;
    $rose(dq_oe) |-> !$past(serial_clock_convert_pin, 1) && $past(serial_clock_convert_pin, 4);
  endproperty
  a_drive_after_fall: assert property (p_drive_after_fall)
    else $error("data drive began without a falling serial clock");
  property p_hold_bit;
    dq_oe && $past(dq_oe) |-> $stable(dq_out);
  endproperty
  a_hold_bit: assert property (p_hold_bit)
    else $error("data bit changed while driven");
  property p_limits_idle;
    !xfer_rst [*5] |-> $stable(high_limit_register) && $stable(low_limit_register);
  endproperty
  a_limits_idle: assert property (p_limits_idle)
    else $error("limit changed outside a transaction");
  property p_write_busy;
    $changed(high_limit_register) || $changed(low_limit_register) |-> nv_busy;
  endproperty
  a_write_busy: assert property (p_write_busy)
    else $error("limit write without busy window");
  property p_nv_len;
    $fell(nv_busy) |-> nv_cnt_q == NV_LEN;
  endproperty
  a_nv_len: assert property (p_nv_len)
    else $error("busy window length wrong");
  property p_conv_len;
    $fell(conv_busy) && single_conversion_bit |->
      conv_cnt_q + 1 >= CONV_LEN && conv_cnt_q <= CONV_LEN + 2;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("single conversion length wrong");
  property p_no_self_start;
    (!xfer_rst && single_conversion_bit && !conv_busy) [*5] |=> !conv_busy;
  endproperty
  a_no_self_start: assert property (p_no_self_start)
    else $error("conversion began without a command");
  c_drive: cover property ($rose(dq_oe));
  c_nv: cover property ($fell(nv_busy));
  c_conv: cover property ($fell(conv_busy));
endmodule // thermo_properties
bind thermometer_serial_command_decoder thermo_properties #(
  .CONV_LEN(CONV_LEN),
  .NV_LEN  (NV_LEN)
) thermo_properties_i (
  .clk(clk), .reset(reset), .serial_clock_convert_pin(serial_clock_convert_pin),
  .xfer_rst(xfer_rst), .dq_out(dq_out), .dq_oe(dq_oe),
  .high_limit_register(high_limit_register), .low_limit_register(low_limit_register),
  .single_conversion_bit(single_conversion_bit), .conv_busy(conv_busy), .nv_busy(nv_busy)
);
`default_nettype wire
